// ### inc/bbdt_map.vh
`ifndef BBDT_MAP_VH
`define BBDT_MAP_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define BBDT_IDX_A_LO 16'h413c
`define BBDT_IDX_A_HI 16'h413d
`define BBDT_IDX_B_LO 16'h413e
`define BBDT_IDX_B_HI 16'h413f
`define BBDT_IDX_CTRL 16'h4140
`define BBDT_IDX_STATUS 16'h4141
`define BBDT_IDX_IRQ_STAT 16'h4142
`define BBDT_IDX_IRQ_MASK 16'h4143
// Descriptor store: 52 byte entries at the start of this 64-index page (index bits 15:6)
`define BBDT_DESC_PAGE 10'h104
`define BBDT_DESC_LEN 52

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BBDT_TMO_LO_RST 8'hd0
`define BBDT_TMO_HI_RST 8'h07
`define BBDT_CTRL_RST 8'h01
`define BBDT_MASK_RST 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BBDT_CTRL_EN 0
`define BBDT_ST_CONN 0
`define BBDT_ST_BB 1
`define BBDT_ST_RUN_A 2
`define BBDT_ST_RUN_B 3
`define BBDT_ST_FAIL 4
`define BBDT_IRQ_ACT 0
`define BBDT_IRQ_EXP_A 1
`define BBDT_IRQ_EXP_B 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define BBDT_CLK_KHZ 50000
`define BBDT_UNIT_MS 10
`define BBDT_DETACH_MS 10

`endif

// ### design/bbdt_top.v
`include "bbdt_map.vh"

module bbdt_top #(
  parameter UNIT_CYC = `BBDT_UNIT_MS * `BBDT_CLK_KHZ,
  parameter DETACH_CYC = `BBDT_DETACH_MS * `BBDT_CLK_KHZ,
  parameter PRE_W = 20
) (
  // Clock and reset
  input wire clock_i,
  input wire srst_i,
  // Avalon-MM slave
  input wire [17:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Power delivery controller pin
  input wire alt_fail_n_i,
  // USB function core events
  input wire addr_set_i,
  input wire altstr_req_i,
  // Function attach control and interrupt
  output wire connect_o,
  output wire billboard_o,
  output wire irq_o
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam [3:0] ST_NORMAL = 4'h1;
  localparam [3:0] ST_DET_BB = 4'h2;
  localparam [3:0] ST_BB = 4'h4;
  localparam [3:0] ST_DET_STD = 4'h8;
  localparam integer UNIT_M1_I = UNIT_CYC - 1;
  localparam integer DETACH_M1_I = DETACH_CYC - 1;
  localparam [PRE_W-1:0] UNIT_M1 = UNIT_M1_I[PRE_W-1:0];
  localparam [PRE_W-1:0] DETACH_M1 = DETACH_M1_I[PRE_W-1:0];

  function [7:0] desc_dflt;
    input integer i;
    begin
      case (i)
        3: desc_dflt = 8'h01;
        4: desc_dflt = 8'h01;
        7: desc_dflt = 8'h80;
        40: desc_dflt = 8'h10;
        41: desc_dflt = 8'h01;
        45: desc_dflt = 8'hff;
        default: desc_dflt = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  reg wait_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg [7:0] to_lo_reg [0:1];
  reg [7:0] to_hi_reg [0:1];
  reg [7:0] ctrl_reg;
  reg [7:0] mask_reg;
  reg [2:0] stat_reg;
  reg [2:0] stat_next;
  reg irq_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg connect_reg;
  reg bb_reg;
  reg armed_reg;
  reg [PRE_W-1:0] hold_reg;
  reg sync1_reg;
  reg sync2_reg;
  reg [7:0] desc_reg [0:`BBDT_DESC_LEN-1];
  wire [15:0] idx_w;
  wire wr_go;
  wire [7:0] wbyte_w;
  wire desc_hit;
  wire fail_w;
  wire [1:0] start_w;
  wire [1:0] exp_w;
  wire [1:0] run_w;
  wire hold_done;
  wire activate_w;

  assign idx_w = avs_address_i[17:2];
  assign wr_go = avs_write_i & ~wait_reg & avs_byteenable_i[0];
  assign wbyte_w = avs_writedata_i[7:0];
  assign desc_hit = (idx_w[15:6] == `BBDT_DESC_PAGE) && (idx_w[5:0] < `BBDT_DESC_LEN);
  assign start_w = {altstr_req_i, addr_set_i};
  assign hold_done = (hold_reg == DETACH_M1);

  // ----------------------------------------
  // Failure pin synchroniser
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (srst_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= alt_fail_n_i;
      sync2_reg <= sync1_reg;
    end
  end

  assign fail_w = ~sync2_reg;
  assign activate_w = fail_w & armed_reg & ctrl_reg[`BBDT_CTRL_EN];

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    if (desc_hit) begin
      rdata_next[7:0] = desc_reg[idx_w[5:0]];
    end else begin
      case (idx_w)
        `BBDT_IDX_A_LO: rdata_next[7:0] = to_lo_reg[0];
        `BBDT_IDX_A_HI: rdata_next[7:0] = to_hi_reg[0];
        `BBDT_IDX_B_LO: rdata_next[7:0] = to_lo_reg[1];
        `BBDT_IDX_B_HI: rdata_next[7:0] = to_hi_reg[1];
        `BBDT_IDX_CTRL: rdata_next[7:0] = ctrl_reg;
        `BBDT_IDX_STATUS: rdata_next[4:0] = {fail_w, run_w, bb_reg, connect_reg};
        `BBDT_IDX_IRQ_STAT: rdata_next[2:0] = stat_reg;
        `BBDT_IDX_IRQ_MASK: rdata_next[7:0] = mask_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // One wait cycle, then a single-cycle answer
  always @(posedge clock_i) begin
    if (srst_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (wait_reg && (avs_read_i || avs_write_i)) begin
      wait_reg <= 1'b0;
      rdata_reg <= rdata_next;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      to_lo_reg[0] <= `BBDT_TMO_LO_RST;
      to_hi_reg[0] <= `BBDT_TMO_HI_RST;
      to_lo_reg[1] <= `BBDT_TMO_LO_RST;
      to_hi_reg[1] <= `BBDT_TMO_HI_RST;
      ctrl_reg <= `BBDT_CTRL_RST;
      mask_reg <= `BBDT_MASK_RST;
    end else if (wr_go) begin
      case (idx_w)
        `BBDT_IDX_A_LO: to_lo_reg[0] <= wbyte_w;
        `BBDT_IDX_A_HI: to_hi_reg[0] <= wbyte_w;
        `BBDT_IDX_B_LO: to_lo_reg[1] <= wbyte_w;
        `BBDT_IDX_B_HI: to_hi_reg[1] <= wbyte_w;
        `BBDT_IDX_CTRL: ctrl_reg <= {7'h00, wbyte_w[`BBDT_CTRL_EN]};
        `BBDT_IDX_IRQ_MASK: mask_reg <= {5'h00, wbyte_w[2:0]};
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ----------------------------------------
  // Descriptor store
  // ----------------------------------------
  genvar d;
  generate
    for (d = 0; d < `BBDT_DESC_LEN; d = d + 1) begin : g_desc
      always @(posedge clock_i) begin
        if (srst_i) begin
          desc_reg[d] <= desc_dflt(d);
        end else if (wr_go && desc_hit && (idx_w[5:0] == d)) begin
          desc_reg[d] <= wbyte_w;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Detach timers
  // ----------------------------------------
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_tmr
      reg run_reg;
      reg [PRE_W-1:0] pre_reg;
      reg [15:0] unit_reg;
      wire [15:0] tmo_w;
      wire [16:0] unit_inc;
      assign tmo_w = {to_hi_reg[t], to_lo_reg[t]};
      assign unit_inc = {1'b0, unit_reg} + 17'h00001;
      // Zero timeout expires after the first unit
      assign exp_w[t] = run_reg && (pre_reg == UNIT_M1) && (unit_inc >= {1'b0, tmo_w});
      assign run_w[t] = run_reg;
      always @(posedge clock_i) begin
        if (srst_i || (state_reg != ST_BB) || exp_w != 2'b00) begin
          run_reg <= 1'b0;
          pre_reg <= {PRE_W{1'b0}};
          unit_reg <= 16'h0000;
        end else if (!run_reg) begin
          run_reg <= start_w[t];
        end else if (pre_reg == UNIT_M1) begin
          pre_reg <= {PRE_W{1'b0}};
          unit_reg <= unit_inc[15:0];
        end else begin
          pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Attach sequencer
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL: begin
        if (activate_w) begin
          state_next = ST_DET_BB;
        end
      end
      ST_DET_BB: begin
        if (hold_done) begin
          state_next = ST_BB;
        end
      end
      ST_BB: begin
        if (exp_w != 2'b00) begin
          state_next = ST_DET_STD;
        end
      end
      ST_DET_STD: begin
        if (hold_done) begin
          state_next = ST_NORMAL;
        end
      end
      default: state_next = ST_NORMAL;
    endcase
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= ST_NORMAL;
      connect_reg <= 1'b1;
      bb_reg <= 1'b0;
      hold_reg <= {PRE_W{1'b0}};
      armed_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      connect_reg <= (state_next == ST_NORMAL) || (state_next == ST_BB);
      bb_reg <= (state_next == ST_BB);
      if (state_next != state_reg) begin
        hold_reg <= {PRE_W{1'b0}};
      end else begin
        hold_reg <= hold_reg + {{(PRE_W-1){1'b0}}, 1'b1};
      end
      // Re-arm only after the failure indication is withdrawn
      if (!fail_w) begin
        armed_reg <= 1'b1;
      end else if (state_reg == ST_DET_BB) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always @* begin
    stat_next = stat_reg;
    if (wr_go && (idx_w == `BBDT_IDX_IRQ_STAT)) begin
      stat_next = stat_reg & ~wbyte_w[2:0];
    end
    stat_next[`BBDT_IRQ_ACT] = stat_next[`BBDT_IRQ_ACT] |
                               ((state_reg == ST_NORMAL) && activate_w);
    stat_next[`BBDT_IRQ_EXP_A] = stat_next[`BBDT_IRQ_EXP_A] | exp_w[0];
    stat_next[`BBDT_IRQ_EXP_B] = stat_next[`BBDT_IRQ_EXP_B] | exp_w[1];
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      stat_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & mask_reg[2:0]);
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign connect_o = connect_reg;
  assign billboard_o = bb_reg;
  assign irq_o = irq_reg;

endmodule // bbdt_top

// ### tb/bbdt_props.sv
module bbdt_props #(
  parameter DETACH_CYC = 3
) (
  input wire clock_i,
  input wire srst_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire connect_o,
  input wire billboard_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Cycles spent detached
  // ----
  int low_cnt;
  always @(posedge clock_i) begin
    if (srst_i || connect_o) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one cycle");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  ack_cause_a: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("answer without request");
  rdata_hi_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  detach_len_a: assert property ($rose(connect_o) |-> low_cnt == DETACH_CYC)
    else $error("detach time wrong");
  bb_conn_a: assert property (billboard_o |-> connect_o)
    else $error("billboard shown while detached");
  bb_rise_a: assert property ($rose(billboard_o) |-> $rose(connect_o))
    else $error("billboard without fresh attach");
  bb_fall_a: assert property ($fell(billboard_o) |-> $fell(connect_o))
    else $error("billboard left without detach");
endmodule // bbdt_props

bind bbdt_top bbdt_props #(.DETACH_CYC(DETACH_CYC)) i_props (.clock_i, .srst_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .connect_o, .billboard_o);

// ### tb/bbdt_host_mdl.sv
module bbdt_host_mdl (
  input wire clock_i,
  output logic addr_set_o,
  output logic altstr_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_set_o = 1'b0;
    altstr_req_o = 1'b0;
  end
  // ----
  // One-cycle host request after a delay
  // ----
  task pulse(input bit str, input int gap);
    repeat (gap + 1) @(posedge clock_i);
    if (str) altstr_req_o <= 1'b1;
    else addr_set_o <= 1'b1;
    @(posedge clock_i);
    addr_set_o <= 1'b0;
    altstr_req_o <= 1'b0;
  endtask
endmodule // bbdt_host_mdl

// ### tb/tb_billboard_detach_timers.sv
`include "bbdt_map.vh"
module tb_billboard_detach_timers;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UC = 4;
  localparam int DC = 3;
  logic clock_i = 0, srst_i = 1, avs_read_i = 0, avs_write_i = 0, alt_fail_n_i = 1;
  logic [17:0] avs_address_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = '0, q;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, connect_o, billboard_o, irq_o, addr_set_i, altstr_req_i;
  int n_fail = 0, num_checks = 0, c;
  always #10 clock_i = ~clock_i;
  bbdt_top #(.UNIT_CYC(UC), .DETACH_CYC(DC)) i_dut (.clock_i, .srst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .alt_fail_n_i, .addr_set_i, .altstr_req_i, .connect_o,
    .billboard_o, .irq_o);
  bbdt_host_mdl i_host (.clock_i, .addr_set_o(addr_set_i), .altstr_req_o(altstr_req_i));
  // ----
  // Common tasks
  // ----
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input bit wr, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge clock_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    if (wr) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  task rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    bus(0, idx, 8'h00, 4'hf);
    chk(q, exp);
  endtask
  task wait_bb(input logic v);
    c = 0;
    while (billboard_o !== v) begin
      @(posedge clock_i);
      c++;
      if (c > 200) begin
        n_fail++;
        report_and_stop;
      end
    end
  endtask
  task fail_pin(input logic v);
    @(posedge clock_i);
    alt_fail_n_i <= v;
  endtask
  // ----
  // Scenarios
  // ----
  task t_defaults;
    logic [7:0] ofs [7] = '{8'h03, 8'h07, 8'h28, 8'h29, 8'h2d, 8'h0c, 8'h04};
    logic [7:0] val [7] = '{8'h01, 8'h80, 8'h10, 8'h01, 8'hff, 8'h00, 8'h01};
    rd_chk(`BBDT_IDX_A_LO, 32'hd0);
    rd_chk(`BBDT_IDX_A_HI, 32'h07);
    rd_chk(`BBDT_IDX_B_LO, 32'hd0);
    rd_chk(`BBDT_IDX_B_HI, 32'h07);
    for (int i = 0; i < 7; i++) rd_chk(16'h4100 + ofs[i], {24'h0, val[i]});
    rd_chk(16'h4000, 32'h0);
    $display("test defaults done");
  endtask
  task t_regs;
    bus(1, `BBDT_IDX_A_LO, 8'h02, 4'h1);
    bus(1, `BBDT_IDX_A_HI, 8'h00, 4'h1);
    bus(1, `BBDT_IDX_B_LO, 8'h03, 4'h1);
    bus(1, `BBDT_IDX_B_HI, 8'h00, 4'h1);
    bus(1, `BBDT_IDX_B_HI, 8'hff, 4'h0);
    bus(1, 16'h4132, 8'h5a, 4'h1);
    rd_chk(16'h4132, 32'h5a);
    rd_chk(`BBDT_IDX_A_LO, 32'h02);
    rd_chk(`BBDT_IDX_A_HI, 32'h00);
    rd_chk(`BBDT_IDX_B_LO, 32'h03);
    rd_chk(`BBDT_IDX_B_HI, 32'h00);
    $display("test registers done");
  endtask
  task t_timer_a;
    i_host.pulse(0, 0);
    rd_chk(`BBDT_IDX_STATUS, 32'h01);
    bus(1, `BBDT_IDX_IRQ_MASK, 8'h02, 4'h1);
    fail_pin(1'b0);
    wait_bb(1'b1);
    chk(connect_o, 1'b1);
    i_host.pulse(0, 2);
    wait_bb(1'b0);
    chk(c >= 2 * UC && c <= 2 * UC + 3, 1'b1);
    chk(connect_o, 1'b0);
    rd_chk(`BBDT_IDX_IRQ_STAT, 32'h03);
    chk(irq_o, 1'b1);
    bus(1, `BBDT_IDX_IRQ_STAT, 8'h02, 4'h1);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 1'b0);
    repeat (DC + 2) @(posedge clock_i);
    rd_chk(`BBDT_IDX_STATUS, 32'h11);
    $display("test timer a done");
  endtask
  task t_timer_b;
    fail_pin(1'b1);
    repeat (4) @(posedge clock_i);
    fail_pin(1'b0);
    wait_bb(1'b1);
    i_host.pulse(1, 0);
    wait_bb(1'b0);
    chk(c >= 3 * UC && c <= 3 * UC + 3, 1'b1);
    rd_chk(`BBDT_IDX_IRQ_STAT, 32'h05);
    repeat (DC + 2) @(posedge clock_i);
    chk(connect_o, 1'b1);
    rd_chk(`BBDT_IDX_STATUS, 32'h11);
    $display("test timer b done");
  endtask
  task t_enable;
    fail_pin(1'b1);
    repeat (4) @(posedge clock_i);
    bus(1, `BBDT_IDX_CTRL, 8'h00, 4'h1);
    rd_chk(`BBDT_IDX_CTRL, 32'h00);
    fail_pin(1'b0);
    repeat (8) @(posedge clock_i);
    rd_chk(`BBDT_IDX_STATUS, 32'h11);
    bus(1, `BBDT_IDX_CTRL, 8'h01, 4'h1);
    wait_bb(1'b1);
    rd_chk(`BBDT_IDX_STATUS, 32'h13);
    rd_chk(`BBDT_IDX_IRQ_MASK, 32'h02);
    $display("test enable done");
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    t_defaults;
    t_regs;
    t_timer_a;
    t_timer_b;
    t_enable;
    report_and_stop;
  end
endmodule // tb_billboard_detach_timers
